//--- dv/etc_checker.sv
`timescale 1ns/10ps
module etc_checker
    import etc_pkg::*;
#(parameter int EXP_W = 32) (
    // Clock, trigger and setup
    input wire logic             mclk,
    input wire logic             rst_n,
    input wire logic             link_trigger,
    input wire logic             hardware_input_line,
    input wire logic             trig_sel_line,
    input wire etc_mode_e        exposure_mode,
    input wire logic             trig_falling,
    input wire logic [EXP_W-1:0] exposure_cycles,
    // Outputs
    input wire logic             exposure_active,
    input wire logic             waiting_trigger,
    input wire logic             readout_start,
    input wire logic             fb_wr_en,
    input wire etc_pix_s         fb_wr
);
    logic             t;
    logic [EXP_W-1:0] len_q;
    // Folded trigger: a rise always means the start edge
    assign t = (trig_sel_line ? hardware_input_line : link_trigger)
        ^ trig_falling;
    always_ff @(posedge mclk) begin
        len_q <= (!rst_n || !exposure_active) ? '0 : len_q + 1'b1;
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    sequence s_rd_begin;
        readout_start ##1 (fb_wr_en && fb_wr.row == 0 && fb_wr.col == 0);
    endsequence
    property p_wait; waiting_trigger == !exposure_active; endproperty
    a_wait: assert property (p_wait) else $error("bad wait");
    property p_start;
        $rose(exposure_active) |-> $past(t, 3) && !$past(t, 5);
    endproperty
    a_start: assert property (p_start) else $error("bad start");
    property p_pend;
        $fell(exposure_active) && exposure_mode == ETC_MODE_PULSE
            |-> !$past(t, 3) && $past(t, 5);
    endproperty
    a_pend: assert property (p_pend) else $error("bad end");
    property p_tlen;
        $fell(exposure_active) && exposure_mode != ETC_MODE_PULSE
            |-> len_q == (exposure_cycles > 1 ? exposure_cycles : 1);
    endproperty
    a_tlen: assert property (p_tlen) else $error("bad length");
    property p_rd; $fell(exposure_active) |-> s_rd_begin; endproperty
    a_rd: assert property (p_rd) else $error("bad readout");
    property p_pulse; readout_start |=> !readout_start; endproperty
    a_pulse: assert property (p_pulse) else $error("long pulse");
    property p_col;
        fb_wr_en && $past(fb_wr_en) && fb_wr.col != 0
            |-> fb_wr.col == $past(fb_wr.col) + 1;
    endproperty
    a_col: assert property (p_col) else $error("bad col");
    property p_row;
        fb_wr_en && $past(fb_wr_en) && fb_wr.col == 0 && !$past(readout_start)
            |-> fb_wr.row == $past(fb_wr.row) + 1;
    endproperty
    a_row: assert property (p_row) else $error("bad row");
endmodule
bind etc_exposure_trigger_control etc_checker #(.EXP_W(EXP_W))
    u_etc_checker (.*);

//--- dv/etc_trig_src.sv
`timescale 1ns/10ps
module etc_trig_src (
    // Clock and selection
    input  wire logic mclk,
    input  wire logic trig_sel_line,
    input  wire logic trig_falling,
    // Trigger lines
    output logic      link_trigger,
    output logic      hardware_input_line
);
    logic act = 1'b0;
    // Unused line carries the inverse, so a wrong source pick shows up
    assign link_trigger = act ^ trig_falling ^ trig_sel_line;
    assign hardware_input_line = ~link_trigger;
    task pulse(input int w);
        @(negedge mclk);
        act = 1'b1;
        repeat (w) @(negedge mclk);
        act = 1'b0;
    endtask
endmodule

//--- dv/tb_top.sv
`timescale 1ns/10ps
module tb_top;
    import etc_pkg::*;
    logic        mclk = 1'b0, rst_n = 1'b0;
    logic        trig_sel_line = 1'b0, trig_falling = 1'b0;
    etc_mode_e   exposure_mode = ETC_MODE_TIMED;
    logic [31:0] exposure_cycles = 32'h4;
    logic [15:0] roi_width = 16'h4, roi_height = 16'h3, sensor_pixel = 16'h0;
    logic [7:0]  rnd = 8'h3b;
    logic        link_trigger, hardware_input_line, exposure_active;
    logic        waiting_trigger, readout_active, readout_start;
    logic        overlapped, fb_wr_en;
    etc_pix_s    fb_wr;
    int          n_fail = 0, cmp_count = 0, frames = 0, writes = 0, len = 0;
    int          i, exp_q[$];
    etc_exposure_trigger_control u_etc_exposure_trigger_control (.*);
    etc_trig_src u_etc_trig_src (.*);
    always #2 mclk = ~mclk;
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    always @(negedge mclk) begin
        rnd <= lfsr(rnd);
        sensor_pixel <= {rnd, ~rnd};
    end
    task check(input logic [31:0] seen, exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task report_and_stop;
        $display("checks=%0d mismatches=%0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic wait_st(input logic [1:0] v);
        int k;
        for (k = 0; k < 400 && {exposure_active, readout_active} !== v; k++)
            @(negedge mclk);
        if ({exposure_active, readout_active} !== v) begin
            n_fail++;
            report_and_stop;
        end
    endtask
    task automatic frame(input int w, e, input logic again);
        exp_q.push_back(e);
        frames++;
        u_etc_trig_src.pulse(w);
        if (again) begin
            repeat (8) @(negedge mclk);
            u_etc_trig_src.pulse(6);
        end
        wait_st(2'b00);
    endtask
    // Each finished exposure is matched against the oldest expected length
    always @(negedge mclk) begin
        if (fb_wr_en === 1'b1) begin
            writes++;
            check(fb_wr.data, sensor_pixel);
        end
        if (exposure_active === 1'b1) len++;
        else if (len > 0) begin
            if (exp_q.size() == 0) check(len, 0);
            else check(len, exp_q.pop_front());
            len = 0;
        end
    end
    initial begin
        repeat (4) @(negedge mclk);
        rst_n = 1'b1;
        repeat (3) @(negedge mclk);
        for (i = 0; i < 4; i++) begin
            {trig_sel_line, trig_falling} = {2{i[0]}};
            exposure_cycles = (i == 3) ? 32'h0 : {28'h0, rnd[3:0]} + 32'h2;
            frame(6, (i == 3) ? 1 : exposure_cycles, 1'b0);
        end
        check(overlapped, 1'b0);
        $display("timed done");
        exposure_cycles = 32'h28;
        frame(6, 40, 1'b1);
        $display("retrigger done");
        exposure_mode = ETC_MODE_PULSE;
        for (i = 0; i < 2; i++) begin
            {trig_sel_line, trig_falling} = {2{i[0]}};
            frame(9 + 3 * i, 9 + 3 * i, 1'b0);
        end
        $display("pulse done");
        exposure_mode = ETC_MODE_TIMED;
        exposure_cycles = 32'h10;
        exp_q.push_back(16);
        exp_q.push_back(16);
        frames += 2;
        u_etc_trig_src.pulse(6);
        wait_st(2'b01);
        u_etc_trig_src.pulse(6);
        check({exposure_active, readout_active}, 2'b11);
        check(overlapped, 1'b1);
        wait_st(2'b00);
        @(negedge mclk);
        check(writes, frames * 12);
        check(exp_q.size(), 0);
        $display("overlap done");
        report_and_stop;
    end
endmodule

//--- verilog/etc_map.svh
`ifndef ETC_MAP_SVH
`define ETC_MAP_SVH

// Exposure duration and geometry widths
`define ETC_EXP_W        32
`define ETC_DIM_W        16
// Reset values of state
`define ETC_EXP_RST      32'h0000_0000
`define ETC_DIM_RST      16'h0000
// Readout pacing: cycles spent on one pixel
`define ETC_PIX_CYCLES   1

`endif

//--- verilog/etc_pkg.sv
package etc_pkg;

    typedef enum logic [1:0] {
        ETC_MODE_TIMED = 2'h1,
        ETC_MODE_PULSE = 2'h2
    } etc_mode_e;

    typedef enum logic [2:0] {
        ETC_EXP_WAIT  = 3'h1,
        ETC_EXP_TIMED = 3'h2,
        ETC_EXP_PULSE = 3'h4
    } etc_exp_e;

    typedef struct packed {
        logic [15:0] row;
        logic [15:0] col;
        logic [15:0] data;
    } etc_pix_s;

    typedef struct packed {
        logic        sync1;
        logic        sync2;
        logic        trig_prev;
        etc_exp_e    exp_st;
        logic [31:0] exp_cnt;
        logic        rd_busy;
        logic [15:0] rd_row;
        logic [15:0] rd_col;
        logic        rd_start;
        logic        wr_en;
        etc_pix_s    wr;
        logic        overlapped;
        logic [31:0] frame_cnt;
        logic [31:0] last_exp;
        logic [31:0] last_rd;
        logic [31:0] rd_len;
    } etc_state_s;

endpackage

//--- verilog/exposure_trigger_control.sv
`timescale 1ns/10ps
`include "etc_map.svh"
module etc_exposure_trigger_control
    import etc_pkg::*;
#(
    parameter int EXP_W = `ETC_EXP_W,
    parameter int DIM_W = `ETC_DIM_W
) (
    // Clock and reset
    input  wire logic              mclk,
    input  wire logic              rst_n,
    // Trigger inputs and selection
    input  wire logic              link_trigger,
    input  wire logic              hardware_input_line,
    input  wire logic              trig_sel_line,
    // Configuration
    input  wire etc_mode_e         exposure_mode,
    input  wire logic              trig_falling,
    input  wire logic [EXP_W-1:0]  exposure_cycles,
    input  wire logic [DIM_W-1:0]  roi_width,
    input  wire logic [DIM_W-1:0]  roi_height,
    // Sensor pixel source
    input  wire logic [15:0]       sensor_pixel,
    // Status
    output logic                   exposure_active,
    output logic                   waiting_trigger,
    output logic                   readout_active,
    output logic                   readout_start,
    output logic                   overlapped,
    // Frame buffer write port
    output logic                   fb_wr_en,
    output etc_pix_s               fb_wr
);

    etc_state_s s_q;
    etc_state_s s_d;

    logic trig_raw;
    logic rise;
    logic fall;
    logic start_edge;
    logic end_edge;
    logic exp_end;
    logic accept;
    logic rd_last;
    logic overlap_now;

    // -------------------------------------------------------------
    // Trigger conditioning
    // -------------------------------------------------------------
    assign trig_raw   = trig_sel_line ? hardware_input_line : link_trigger;
    // Two synchroniser stages put two cycles between a pin change and its
    // edge pulse, and the state register adds one more; exposure therefore lags
    // the trigger by a fixed amount that is the same for start and end.

    // Only the second stage is looked at; first stage may be metastable
    assign rise       = s_q.sync2 & ~s_q.trig_prev;
    assign fall       = ~s_q.sync2 & s_q.trig_prev;
    assign start_edge = trig_falling ? fall : rise;
    assign end_edge   = trig_falling ? rise : fall;
    // Waiting state only; triggers in exposure states are dropped
    assign accept     = start_edge && (s_q.exp_st == ETC_EXP_WAIT);
    assign rd_last    = s_q.rd_busy && (s_q.rd_col == roi_width - 1'b1)
                        && (s_q.rd_row == roi_height - 1'b1);

    // Period is counted from the last accepted start; the counter wraps
    // after 2^32 cycles, so a very slow trigger may look overlapped.
    // The first frame compares against zero and is never overlapped.
    assign overlap_now = (s_q.frame_cnt <= s_q.last_exp + s_q.rd_len);

    always_comb begin
        s_d           = s_q;
        s_d.sync1     = trig_raw;
        s_d.sync2     = s_q.sync1;
        s_d.trig_prev = s_q.sync2;
        s_d.rd_start  = 1'b0;
        s_d.wr_en     = 1'b0;
        exp_end       = 1'b0;
        s_d.frame_cnt = s_q.frame_cnt + 1'b1;

        // ---------------------------------------------------------
        // Exposure state machine
        // ---------------------------------------------------------
        unique case (s_q.exp_st)
            ETC_EXP_WAIT: begin
                if (accept) begin
                    s_d.exp_cnt = 32'h1;
                    // Overlap judged from start-to-start period
                    s_d.overlapped = overlap_now;
                    s_d.frame_cnt = 32'h1;
                    s_d.last_exp  = 32'h0;
                    if (exposure_mode == ETC_MODE_PULSE) begin
                        s_d.exp_st = ETC_EXP_PULSE;
                    end else begin
                        s_d.exp_st = ETC_EXP_TIMED;
                    end
                end
            end

            ETC_EXP_TIMED: begin
                s_d.exp_cnt = s_q.exp_cnt + 1'b1;
                // Pulse length plays no part here
                if (s_q.exp_cnt >= exposure_cycles) begin
                    exp_end = 1'b1;
                end
            end

            ETC_EXP_PULSE: begin
                s_d.exp_cnt = s_q.exp_cnt + 1'b1;
                if (end_edge) begin
                    exp_end = 1'b1;
                end
            end

            // Only reachable from a corrupted state code; recover to idle
            default: begin
                s_d.exp_st = ETC_EXP_WAIT;
            end
        endcase

        // A second exposure that ends while readout still runs restarts
        // readout for the new frame; the old frame is cut short. The
        // trigger source is expected to avoid this case.
        if (exp_end) begin
            // One shutter event for every line at once
            s_d.exp_st   = ETC_EXP_WAIT;
            s_d.last_exp = s_q.exp_cnt;
            s_d.rd_start = 1'b1;
            s_d.rd_busy  = 1'b1;
            s_d.rd_row   = 16'h0;
            s_d.rd_col   = 16'h0;
            // Readout length follows the region size
            s_d.rd_len   = 32'(roi_width) * 32'(roi_height);
        end else if (s_q.rd_busy) begin
            // -----------------------------------------------------
            // Line-by-line readout, runs under a new exposure
            // -----------------------------------------------------
            s_d.wr_en    = 1'b1;
            s_d.wr.row   = s_q.rd_row;
            s_d.wr.col   = s_q.rd_col;
            s_d.wr.data  = sensor_pixel;
            if (rd_last) begin
                s_d.rd_busy = 1'b0;
            end else if (s_q.rd_col == roi_width - 1'b1) begin
                s_d.rd_col = 16'h0;
                s_d.rd_row = s_q.rd_row + 1'b1;
            end else begin
                s_d.rd_col = s_q.rd_col + 1'b1;
            end
        end
        // No gate on overlap: readout never blocks a new start
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            // Every field gets a constant so no state leaks across reset
            s_q.sync1      <= 1'b0;
            s_q.sync2      <= 1'b0;
            s_q.trig_prev  <= 1'b0;
            s_q.exp_st     <= ETC_EXP_WAIT;
            s_q.exp_cnt    <= `ETC_EXP_RST;
            s_q.rd_busy    <= 1'b0;
            s_q.rd_row     <= `ETC_DIM_RST;
            s_q.rd_col     <= `ETC_DIM_RST;
            s_q.rd_start   <= 1'b0;
            s_q.wr_en      <= 1'b0;
            s_q.wr         <= '0;
            s_q.overlapped <= 1'b0;
            s_q.frame_cnt  <= `ETC_EXP_RST;
            s_q.last_exp   <= `ETC_EXP_RST;
            s_q.last_rd    <= `ETC_EXP_RST;
            s_q.rd_len     <= `ETC_EXP_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // -------------------------------------------------------------
    // Exposure status outputs
    // -------------------------------------------------------------
    // Decoded straight from the state register, so no glitch reaches
    // the pin and the two flags are always exact complements.
    assign exposure_active = (s_q.exp_st != ETC_EXP_WAIT);
    assign waiting_trigger = (s_q.exp_st == ETC_EXP_WAIT);

    // -------------------------------------------------------------
    // Readout status outputs
    // -------------------------------------------------------------
    assign readout_active  = s_q.rd_busy;
    assign readout_start   = s_q.rd_start;
    assign overlapped      = s_q.overlapped;

    // -------------------------------------------------------------
    // Frame buffer write port
    // -------------------------------------------------------------
    // Address and data come from one register stage with the strobe
    assign fb_wr_en        = s_q.wr_en;
    assign fb_wr           = s_q.wr;

endmodule
